/* hdl/dpf_pkg.sv */
/*
 * Shared constants and carriers of the PCIe core-facing port block.
 * Assumes a single 40 MHz system clock; port groups advance on enables.
 */
`default_nettype none
package dpf_pkg;
	// ==========================================
	// Stream geometry
	localparam int STREAM_BUS_WIDTH = 256;
	localparam int KEEP_W = STREAM_BUS_WIDTH / 8;
	localparam int TAIL_W = $clog2(KEEP_W + 1);
	localparam int FIFO_DEPTH = 8;
	// ==========================================
	// Register port geometry
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int RESP_W = 2;
	localparam logic [RESP_W-1:0] RESP_RESET = 2'h0;

	typedef struct packed {
		logic [STREAM_BUS_WIDTH-1:0] hdr;
		logic [STREAM_BUS_WIDTH-1:0] data;
		logic [TAIL_W-1:0]           tail;
		logic                        last;
	} dpf_ob_beat_t;

	typedef struct packed {
		logic [STREAM_BUS_WIDTH-1:0] hdr;
		logic                        hvalid;
		logic [STREAM_BUS_WIDTH-1:0] data;
		logic [KEEP_W-1:0]           keep;
		logic                        last;
	} dpf_ib_beat_t;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [STRB_W-1:0] wstrb;
	} dpf_csr_cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [RESP_W-1:0] resp;
		logic              write;
	} dpf_csr_rsp_t;

	typedef enum logic [2:0] {
		CSR_IDLE  = 3'h0,
		CSR_WRITE = 3'h1,
		CSR_WRESP = 3'h2,
		CSR_RADDR = 3'h3,
		CSR_RDATA = 3'h4
	} dpf_csr_state_t;
endpackage
`default_nettype wire

/* hdl/dpf_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; clr_i is a synchronous group reset.
 */
`default_nettype none
module dpf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output var  logic             in_ready_o,
	output var  logic             out_valid_o,
	output      logic [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [PW:0]      count, next_count;
	logic             push, pop;

	assign push = ce_i && in_valid_i && in_ready_o;
	assign pop = ce_i && out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else if (clr_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_o <= next_count != FULL;
			out_valid_o <= next_count != '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

/* hdl/dpf_top.sv */
/*
 * Core-facing ports of a DMA engine: outbound and inbound packet streams
 * and a register-port manager toward the PCIe streaming core.
 * Assumes all inputs synchronous to CLK_I; each port group advances only
 * on its own clock-enable pulse and has its own active-low reset.
 */
// Functional notes
// - Three group clocks: stream, memory-mapped and lite register port.
// - Each port signal is sampled on its own group's clock edge.
// - Register port logic runs on the lite clock, not stream clock.
// - Three active-low resets, each clearing only its own group.
// - Outbound packets leave on the transmit port, header and data apart.
// - Single segment, 256 bits for Gen4 x4, 128 bits for Gen3 x4; block is fixed at 256 bits.
// - Receiver drives ready, sender drives valid with each transfer.
// - Outbound lanes all valid except final beat, which is contiguous.
// - Sender marks final beat of each transmission with last flag.
// - Outbound header-valid high exactly when header bus is valid.
// - Inbound packets all taken on receive port, ready gives backpressure.
// - Inbound header bus used only when its header-valid is high.
// - Lite manager reaches config space and core soft registers.
// - Register port has no secure distinction; all accesses secure.
// - 20-bit byte address on write-address and read-address channels.
// - 32-bit write data with four byte strobes.
// - Block accepts write responses; core returns 2-bit status.
// - Core returns 32-bit read data and 2-bit status to the block.
`default_nettype none
module dpf_top #(
	parameter int FIFO_DEPTH = dpf_pkg::FIFO_DEPTH
) (
	input  wire logic                                CLK_I,
	input  wire logic                                SYS_RST_I,
	input  wire logic                                STREAM_PORT_CLOCK_EN_I,
	input  wire logic                                MEMMAP_PORT_CLOCK_EN_I,
	input  wire logic                                LITE_PORT_CLOCK_EN_I,
	input  wire logic                                STREAM_PORT_RESET_N_I,
	input  wire logic                                MEMMAP_PORT_RESET_N_I,
	input  wire logic                                LITE_PORT_RESET_N_I,
	output var  logic                                MEMMAP_ACTIVE_O,
	input  wire logic                                OB_IN_VALID_I,
	input  wire dpf_pkg::dpf_ob_beat_t               OB_IN_I,
	output var  logic                                OB_IN_READY_O,
	output var  logic                                OUTBOUND_VALID_O,
	input  wire logic                                OUTBOUND_READY_I,
	output var  logic [dpf_pkg::STREAM_BUS_WIDTH-1:0] OUTBOUND_DATA_O,
	output var  logic [dpf_pkg::KEEP_W-1:0]          OUTBOUND_BYTE_QUALIFIER_O,
	output var  logic                                OUTBOUND_LAST_BEAT_O,
	output var  logic                                OUTBOUND_HEADER_VALID_O,
	output var  logic [dpf_pkg::STREAM_BUS_WIDTH-1:0] OUTBOUND_HEADER_BUS_O,
	input  wire logic                                INBOUND_VALID_I,
	output var  logic                                INBOUND_READY_O,
	input  wire logic [dpf_pkg::STREAM_BUS_WIDTH-1:0] INBOUND_DATA_I,
	input  wire logic [dpf_pkg::KEEP_W-1:0]          INBOUND_BYTE_QUALIFIER_I,
	input  wire logic                                INBOUND_LAST_BEAT_I,
	input  wire logic                                INBOUND_HEADER_VALID_I,
	input  wire logic [dpf_pkg::STREAM_BUS_WIDTH-1:0] INBOUND_HEADER_BUS_I,
	output var  logic                                IB_OUT_VALID_O,
	output var  dpf_pkg::dpf_ib_beat_t               IB_OUT_O,
	input  wire logic                                IB_OUT_READY_I,
	output var  logic                                CSR_AWVALID_O,
	input  wire logic                                CSR_AWREADY_I,
	output var  logic [dpf_pkg::ADDR_W-1:0]          CSR_AWADDR_O,
	output var  logic                                CSR_WVALID_O,
	input  wire logic                                CSR_WREADY_I,
	output var  logic [dpf_pkg::DATA_W-1:0]          CSR_WDATA_O,
	output var  logic [dpf_pkg::STRB_W-1:0]          CSR_WSTRB_O,
	input  wire logic                                CSR_BVALID_I,
	output var  logic                                CSR_BREADY_O,
	input  wire logic [dpf_pkg::RESP_W-1:0]          CSR_BRESP_I,
	output var  logic                                CSR_ARVALID_O,
	input  wire logic                                CSR_ARREADY_I,
	output var  logic [dpf_pkg::ADDR_W-1:0]          CSR_ARADDR_O,
	input  wire logic                                CSR_RVALID_I,
	output var  logic                                CSR_RREADY_O,
	input  wire logic [dpf_pkg::DATA_W-1:0]          CSR_RDATA_I,
	input  wire logic [dpf_pkg::RESP_W-1:0]          CSR_RRESP_I,
	input  wire logic                                CMD_VALID_I,
	input  wire dpf_pkg::dpf_csr_cmd_t               CMD_I,
	output var  logic                                CMD_READY_O,
	output var  logic                                RSP_VALID_O,
	output var  dpf_pkg::dpf_csr_rsp_t               RSP_O
);
	localparam int W = dpf_pkg::STREAM_BUS_WIDTH;
	localparam int KW = dpf_pkg::KEEP_W;
	localparam int TW = dpf_pkg::TAIL_W;

	// ==========================================
	// Outbound path: FIFO then output stage
	dpf_pkg::dpf_ob_beat_t fifo_beat;
	logic                  fifo_valid, stage_free;
	logic                  mid_pkt, next_mid_pkt;
	logic                  next_ob_valid, next_ob_last, next_ob_hvalid;
	logic [W-1:0]          next_ob_data, next_ob_hdr;
	logic [KW-1:0]         next_ob_keep, tail_keep;

	// Stage refills only when empty or draining
	assign stage_free = !OUTBOUND_VALID_O || OUTBOUND_READY_I;

	dpf_fifo #(
		.WIDTH($bits(dpf_pkg::dpf_ob_beat_t)),
		.DEPTH(FIFO_DEPTH)
	) u_ob_fifo (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.clr_i      (!STREAM_PORT_RESET_N_I),
		.ce_i       (STREAM_PORT_CLOCK_EN_I),
		.in_valid_i (OB_IN_VALID_I),
		.in_data_i  (OB_IN_I),
		.in_ready_o (OB_IN_READY_O),
		.out_valid_o(fifo_valid),
		.out_data_o (fifo_beat),
		.out_ready_i(stage_free)
	);

	// Tail count gives lanes from byte 0 up, so never sparse
	always_comb begin
		for (int i = 0; i < KW; i++) begin
			tail_keep[i] = TW'(i) < fifo_beat.tail;
		end
	end

	always_comb begin
		next_ob_valid = OUTBOUND_VALID_O;
		next_ob_data = OUTBOUND_DATA_O;
		next_ob_keep = OUTBOUND_BYTE_QUALIFIER_O;
		next_ob_last = OUTBOUND_LAST_BEAT_O;
		next_ob_hvalid = OUTBOUND_HEADER_VALID_O;
		next_ob_hdr = OUTBOUND_HEADER_BUS_O;
		next_mid_pkt = mid_pkt;
		if (stage_free) begin
			next_ob_valid = fifo_valid;
			next_ob_hvalid = 1'b0;
			if (fifo_valid) begin
				next_ob_data = fifo_beat.data;
				next_ob_last = fifo_beat.last;
				next_ob_keep = '1;
				if (fifo_beat.last && fifo_beat.tail != '0) begin
					next_ob_keep = tail_keep;
				end
				next_ob_hvalid = !mid_pkt;
				next_ob_hdr = mid_pkt ? '0 : fifo_beat.hdr;
				next_mid_pkt = !fifo_beat.last;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			OUTBOUND_VALID_O <= 1'b0;
			OUTBOUND_DATA_O <= '0;
			OUTBOUND_BYTE_QUALIFIER_O <= '0;
			OUTBOUND_LAST_BEAT_O <= 1'b0;
			OUTBOUND_HEADER_VALID_O <= 1'b0;
			OUTBOUND_HEADER_BUS_O <= '0;
			mid_pkt <= 1'b0;
		end else if (!STREAM_PORT_RESET_N_I) begin
			OUTBOUND_VALID_O <= 1'b0;
			OUTBOUND_DATA_O <= '0;
			OUTBOUND_BYTE_QUALIFIER_O <= '0;
			OUTBOUND_LAST_BEAT_O <= 1'b0;
			OUTBOUND_HEADER_VALID_O <= 1'b0;
			OUTBOUND_HEADER_BUS_O <= '0;
			mid_pkt <= 1'b0;
		end else if (STREAM_PORT_CLOCK_EN_I) begin
			OUTBOUND_VALID_O <= next_ob_valid;
			OUTBOUND_DATA_O <= next_ob_data;
			OUTBOUND_BYTE_QUALIFIER_O <= next_ob_keep;
			OUTBOUND_LAST_BEAT_O <= next_ob_last;
			OUTBOUND_HEADER_VALID_O <= next_ob_hvalid;
			OUTBOUND_HEADER_BUS_O <= next_ob_hdr;
			mid_pkt <= next_mid_pkt;
		end
	end

	// ==========================================
	// Inbound path: one-entry holding register
	// Trade-off: ready drops while holding, so at most one beat in two
	dpf_pkg::dpf_ib_beat_t next_ib_beat;
	logic                  next_ib_valid, ib_take;

	assign ib_take = INBOUND_VALID_I && INBOUND_READY_O;

	always_comb begin
		next_ib_valid = IB_OUT_VALID_O && !IB_OUT_READY_I;
		next_ib_beat = IB_OUT_O;
		if (ib_take) begin
			next_ib_valid = 1'b1;
			next_ib_beat.data = INBOUND_DATA_I;
			next_ib_beat.keep = INBOUND_BYTE_QUALIFIER_I;
			next_ib_beat.last = INBOUND_LAST_BEAT_I;
			next_ib_beat.hvalid = INBOUND_HEADER_VALID_I;
			next_ib_beat.hdr = INBOUND_HEADER_VALID_I ?
				INBOUND_HEADER_BUS_I : '0;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			IB_OUT_VALID_O <= 1'b0;
			IB_OUT_O <= '0;
			INBOUND_READY_O <= 1'b0;
		end else if (!STREAM_PORT_RESET_N_I) begin
			IB_OUT_VALID_O <= 1'b0;
			IB_OUT_O <= '0;
			INBOUND_READY_O <= 1'b0;
		end else if (STREAM_PORT_CLOCK_EN_I) begin
			IB_OUT_VALID_O <= next_ib_valid;
			IB_OUT_O <= next_ib_beat;
			INBOUND_READY_O <= !next_ib_valid;
		end
	end

	// ==========================================
	// Memory-mapped group: out-of-reset status only
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			MEMMAP_ACTIVE_O <= 1'b0;
		end else if (!MEMMAP_PORT_RESET_N_I) begin
			MEMMAP_ACTIVE_O <= 1'b0;
		end else if (MEMMAP_PORT_CLOCK_EN_I) begin
			MEMMAP_ACTIVE_O <= 1'b1;
		end
	end

	// ==========================================
	// Register port manager
	dpf_pkg::dpf_csr_state_t state, next_state;
	dpf_pkg::dpf_csr_rsp_t   next_rsp;
	logic                    next_aw, next_w, next_b, next_ar, next_r;
	logic                    next_cmd_ready, next_rsp_valid;
	logic [dpf_pkg::ADDR_W-1:0] next_addr;
	logic [dpf_pkg::DATA_W-1:0] next_wdata;
	logic [dpf_pkg::STRB_W-1:0] next_wstrb;

	always_comb begin
		next_state = state;
		next_aw = CSR_AWVALID_O;
		next_w = CSR_WVALID_O;
		next_b = CSR_BREADY_O;
		next_ar = CSR_ARVALID_O;
		next_r = CSR_RREADY_O;
		next_cmd_ready = CMD_READY_O;
		next_rsp_valid = 1'b0;
		next_rsp = RSP_O;
		next_addr = CSR_AWADDR_O;
		next_wdata = CSR_WDATA_O;
		next_wstrb = CSR_WSTRB_O;
		unique case (state)
			dpf_pkg::CSR_IDLE: begin
				next_cmd_ready = 1'b1;
				if (CMD_VALID_I && CMD_READY_O) begin
					next_cmd_ready = 1'b0;
					// No protection field: every access goes out secure
					next_addr = CMD_I.addr;
					next_wdata = CMD_I.wdata;
					next_wstrb = CMD_I.wstrb;
					next_aw = CMD_I.write;
					next_w = CMD_I.write;
					next_ar = !CMD_I.write;
					next_state = CMD_I.write ? dpf_pkg::CSR_WRITE :
						dpf_pkg::CSR_RADDR;
				end
			end
			dpf_pkg::CSR_WRITE: begin
				if (CSR_AWREADY_I) begin
					next_aw = 1'b0;
				end
				if (CSR_WREADY_I) begin
					next_w = 1'b0;
				end
				if (!next_aw && !next_w) begin
					next_b = 1'b1;
					next_state = dpf_pkg::CSR_WRESP;
				end
			end
			dpf_pkg::CSR_WRESP: begin
				if (CSR_BVALID_I) begin
					next_b = 1'b0;
					next_rsp = '{rdata: '0, resp: CSR_BRESP_I, write: 1'b1};
					next_rsp_valid = 1'b1;
					next_cmd_ready = 1'b1;
					next_state = dpf_pkg::CSR_IDLE;
				end
			end
			dpf_pkg::CSR_RADDR: begin
				if (CSR_ARREADY_I) begin
					next_ar = 1'b0;
					next_r = 1'b1;
					next_state = dpf_pkg::CSR_RDATA;
				end
			end
			dpf_pkg::CSR_RDATA: begin
				if (CSR_RVALID_I) begin
					next_r = 1'b0;
					next_rsp = '{rdata: CSR_RDATA_I, resp: CSR_RRESP_I,
						write: 1'b0};
					next_rsp_valid = 1'b1;
					next_cmd_ready = 1'b1;
					next_state = dpf_pkg::CSR_IDLE;
				end
			end
			default: begin
				next_aw = 1'b0;
				next_w = 1'b0;
				next_b = 1'b0;
				next_ar = 1'b0;
				next_r = 1'b0;
				next_cmd_ready = 1'b1;
				next_state = dpf_pkg::CSR_IDLE;
			end
		endcase
	end

	// Both address outputs share one register; only one channel is live
	assign CSR_ARADDR_O = CSR_AWADDR_O;

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state <= dpf_pkg::CSR_IDLE;
			{CSR_AWVALID_O, CSR_WVALID_O, CSR_BREADY_O} <= 3'h0;
			{CSR_ARVALID_O, CSR_RREADY_O, RSP_VALID_O} <= 3'h0;
			CMD_READY_O <= 1'b0;
			RSP_O <= '{rdata: '0, resp: dpf_pkg::RESP_RESET, write: 1'b0};
			CSR_AWADDR_O <= '0;
			CSR_WDATA_O <= '0;
			CSR_WSTRB_O <= '0;
		end else if (!LITE_PORT_RESET_N_I) begin
			state <= dpf_pkg::CSR_IDLE;
			{CSR_AWVALID_O, CSR_WVALID_O, CSR_BREADY_O} <= 3'h0;
			{CSR_ARVALID_O, CSR_RREADY_O, RSP_VALID_O} <= 3'h0;
			CMD_READY_O <= 1'b0;
			RSP_O <= '{rdata: '0, resp: dpf_pkg::RESP_RESET, write: 1'b0};
			CSR_AWADDR_O <= '0;
			CSR_WDATA_O <= '0;
			CSR_WSTRB_O <= '0;
		end else if (LITE_PORT_CLOCK_EN_I) begin
			state <= next_state;
			CSR_AWVALID_O <= next_aw;
			CSR_WVALID_O <= next_w;
			CSR_BREADY_O <= next_b;
			CSR_ARVALID_O <= next_ar;
			CSR_RREADY_O <= next_r;
			CMD_READY_O <= next_cmd_ready;
			RSP_VALID_O <= next_rsp_valid;
			RSP_O <= next_rsp;
			CSR_AWADDR_O <= next_addr;
			CSR_WDATA_O <= next_wdata;
			CSR_WSTRB_O <= next_wstrb;
		end
	end

	// ==========================================
	// Checks
	logic [KW-1:0] keep_inc;
	assign keep_inc = OUTBOUND_BYTE_QUALIFIER_O + 1'b1;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_tx_hold_beat: assert property (OUTBOUND_VALID_O && !OUTBOUND_READY_I && STREAM_PORT_RESET_N_I |=> OUTBOUND_VALID_O && $stable(OUTBOUND_DATA_O) && $stable(OUTBOUND_LAST_BEAT_O))
		else $error("outbound beat changed before acceptance");
	a_tx_keep_full: assert property (OUTBOUND_VALID_O && !OUTBOUND_LAST_BEAT_O |-> &OUTBOUND_BYTE_QUALIFIER_O)
		else $error("outbound lanes not full on inner beat");
	a_tx_keep_contig: assert property (OUTBOUND_VALID_O |-> OUTBOUND_BYTE_QUALIFIER_O[0] && (keep_inc & OUTBOUND_BYTE_QUALIFIER_O) == '0)
		else $error("outbound lanes sparse");
	a_tx_hdr_gated: assert property (!OUTBOUND_VALID_O |-> !OUTBOUND_HEADER_VALID_O)
		else $error("header valid without beat");
	a_tx_hdr_once: assert property (OUTBOUND_VALID_O && OUTBOUND_READY_I && !OUTBOUND_LAST_BEAT_O && STREAM_PORT_CLOCK_EN_I && STREAM_PORT_RESET_N_I |=> !OUTBOUND_HEADER_VALID_O)
		else $error("second header within packet");
	a_rx_back_press: assert property (IB_OUT_VALID_O |-> !INBOUND_READY_O)
		else $error("inbound ready while holding a beat");
	a_rx_hdr_mask: assert property (IB_OUT_VALID_O && !IB_OUT_O.hvalid |-> IB_OUT_O.hdr == '0)
		else $error("inbound header passed without valid");
	a_csr_aw_hold: assert property (CSR_AWVALID_O && !CSR_AWREADY_I && LITE_PORT_RESET_N_I |=> CSR_AWVALID_O && $stable(CSR_AWADDR_O))
		else $error("write address dropped early");
	a_csr_w_hold: assert property (CSR_WVALID_O && !CSR_WREADY_I && LITE_PORT_RESET_N_I |=> CSR_WVALID_O && $stable(CSR_WDATA_O) && $stable(CSR_WSTRB_O))
		else $error("write data dropped early");
	a_csr_bresp_pass: assert property (CSR_BVALID_I && CSR_BREADY_O && LITE_PORT_CLOCK_EN_I && LITE_PORT_RESET_N_I |=> RSP_VALID_O && RSP_O.write && RSP_O.resp == $past(CSR_BRESP_I))
		else $error("write status not returned");
	a_csr_rdata_pass: assert property (CSR_RVALID_I && CSR_RREADY_O && LITE_PORT_CLOCK_EN_I && LITE_PORT_RESET_N_I |=> RSP_VALID_O && RSP_O.rdata == $past(CSR_RDATA_I))
		else $error("read data not returned");

	c_tx_two_beat: cover property (OUTBOUND_VALID_O && OUTBOUND_READY_I && OUTBOUND_HEADER_VALID_O && !OUTBOUND_LAST_BEAT_O ##[1:8] OUTBOUND_VALID_O && OUTBOUND_READY_I && OUTBOUND_LAST_BEAT_O);
	c_tx_fifo_full: cover property (!OB_IN_READY_O);
	c_csr_write: cover property (CSR_BVALID_I && CSR_BREADY_O);
	c_csr_read: cover property (CSR_RVALID_I && CSR_RREADY_O);
endmodule
`default_nettype wire

/* sim/dpf_core_model.sv */
/*
 * Behavioural model of the PCIe streaming core: outbound sink and
 * register-port responder. Assumes one clock; slow_i withholds every ready.
 */
`default_nettype none
module dpf_core_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	output logic             ob_ready_o,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [19:0] awaddr_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	output logic [1:0]       bresp_o,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	input  wire logic [19:0] araddr_i,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// Responder
	logic [31:0] mem [16];
	assign ob_ready_o = !slow_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{awready_o, wready_o, bvalid_o, arready_o, rvalid_o} <= '0;
			{bresp_o, rresp_o, rdata_o} <= '0;
		end else begin
			// Both write channels taken together, one write in flight
			awready_o <= awvalid_i & wvalid_i & !awready_o & !bvalid_o & !slow_i;
			wready_o <= awvalid_i & wvalid_i & !awready_o & !bvalid_o & !slow_i;
			arready_o <= arvalid_i & !arready_o & !rvalid_o & !slow_i;
			if (awvalid_i & awready_o) begin
				for (int b = 0; b < 4; b++)
					if (wstrb_i[b])
						mem[awaddr_i[5:2]][8*b+:8] <= wdata_i[8*b+:8];
				bvalid_o <= 1'b1;
				// No secure flag: only the address picks the status
				bresp_o <= (awaddr_i[19:12] != 8'h00) ? 2'h2 : 2'h0;
			end else if (bvalid_o & bready_i) begin
				bvalid_o <= 1'b0;
				bresp_o <= ~bresp_o;
			end
			if (arvalid_i & arready_o) begin
				rvalid_o <= 1'b1;
				rdata_o <= mem[araddr_i[5:2]];
				rresp_o <= (araddr_i[19:12] != 8'h00) ? 2'h2 : 2'h0;
			end else if (rvalid_o & rready_i) begin
				rvalid_o <= 1'b0;
				// Released bus shows a changed value, never the last one
				{rdata_o, rresp_o} <= ~{rdata_o, rresp_o};
			end
		end
	end
endmodule
`default_nettype wire

/* sim/tb_dpf_top.sv */
/*
 * Self-checking bench of the core-facing ports.
 * Assumes the core model beside it; inputs change at falling edges.
 */
`default_nettype none
module tb_dpf_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_I = 0, SYS_RST_I = 1, slow = 1;
	logic STREAM_PORT_CLOCK_EN_I = 1, MEMMAP_PORT_CLOCK_EN_I = 1;
	logic LITE_PORT_CLOCK_EN_I = 1, STREAM_PORT_RESET_N_I = 0;
	logic MEMMAP_PORT_RESET_N_I = 0, LITE_PORT_RESET_N_I = 0;
	logic MEMMAP_ACTIVE_O, OB_IN_VALID_I = 0, OB_IN_READY_O;
	logic OUTBOUND_VALID_O, OUTBOUND_READY_I, OUTBOUND_LAST_BEAT_O;
	logic OUTBOUND_HEADER_VALID_O, INBOUND_VALID_I = 0, INBOUND_READY_O;
	logic [255:0] OUTBOUND_DATA_O, OUTBOUND_HEADER_BUS_O;
	logic [255:0] INBOUND_DATA_I = '0, INBOUND_HEADER_BUS_I = '0;
	logic [31:0] OUTBOUND_BYTE_QUALIFIER_O, INBOUND_BYTE_QUALIFIER_I = '0;
	logic INBOUND_LAST_BEAT_I = 0, INBOUND_HEADER_VALID_I = 0;
	logic IB_OUT_VALID_O, IB_OUT_READY_I = 0, CMD_VALID_I = 0;
	logic CMD_READY_O, RSP_VALID_O, CSR_AWVALID_O, CSR_AWREADY_I;
	logic CSR_WVALID_O, CSR_WREADY_I, CSR_BVALID_I, CSR_BREADY_O;
	logic CSR_ARVALID_O, CSR_ARREADY_I, CSR_RVALID_I, CSR_RREADY_O;
	logic [19:0] CSR_AWADDR_O, CSR_ARADDR_O;
	logic [31:0] CSR_WDATA_O, CSR_RDATA_I;
	logic [3:0] CSR_WSTRB_O;
	logic [1:0] CSR_BRESP_I, CSR_RRESP_I;
	dpf_pkg::dpf_ob_beat_t OB_IN_I = '0;
	dpf_pkg::dpf_ib_beat_t IB_OUT_O;
	dpf_pkg::dpf_csr_cmd_t CMD_I = '0;
	dpf_pkg::dpf_csr_rsp_t RSP_O;
	logic [49:0] obq[$];
	int mismatches = 0, checked = 0;

	dpf_top dpf_top_inst (.CLK_I, .SYS_RST_I, .STREAM_PORT_CLOCK_EN_I,
		.MEMMAP_PORT_CLOCK_EN_I, .LITE_PORT_CLOCK_EN_I, .STREAM_PORT_RESET_N_I,
		.MEMMAP_PORT_RESET_N_I, .LITE_PORT_RESET_N_I, .MEMMAP_ACTIVE_O,
		.OB_IN_VALID_I, .OB_IN_I, .OB_IN_READY_O, .OUTBOUND_VALID_O,
		.OUTBOUND_READY_I, .OUTBOUND_DATA_O, .OUTBOUND_BYTE_QUALIFIER_O,
		.OUTBOUND_LAST_BEAT_O, .OUTBOUND_HEADER_VALID_O, .OUTBOUND_HEADER_BUS_O,
		.INBOUND_VALID_I, .INBOUND_READY_O, .INBOUND_DATA_I,
		.INBOUND_BYTE_QUALIFIER_I, .INBOUND_LAST_BEAT_I, .INBOUND_HEADER_VALID_I,
		.INBOUND_HEADER_BUS_I, .IB_OUT_VALID_O, .IB_OUT_O, .IB_OUT_READY_I,
		.CSR_AWVALID_O, .CSR_AWREADY_I, .CSR_AWADDR_O, .CSR_WVALID_O,
		.CSR_WREADY_I, .CSR_WDATA_O, .CSR_WSTRB_O, .CSR_BVALID_I, .CSR_BREADY_O,
		.CSR_BRESP_I, .CSR_ARVALID_O, .CSR_ARREADY_I, .CSR_ARADDR_O,
		.CSR_RVALID_I, .CSR_RREADY_O, .CSR_RDATA_I, .CSR_RRESP_I, .CMD_VALID_I,
		.CMD_I, .CMD_READY_O, .RSP_VALID_O, .RSP_O);
	dpf_core_model dpf_core_model_inst (.clk_i(CLK_I), .rst_i(SYS_RST_I),
		.slow_i(slow), .ob_ready_o(OUTBOUND_READY_I), .awvalid_i(CSR_AWVALID_O),
		.awready_o(CSR_AWREADY_I), .awaddr_i(CSR_AWADDR_O),
		.wvalid_i(CSR_WVALID_O), .wready_o(CSR_WREADY_I), .wdata_i(CSR_WDATA_O),
		.wstrb_i(CSR_WSTRB_O), .bvalid_o(CSR_BVALID_I), .bready_i(CSR_BREADY_O),
		.bresp_o(CSR_BRESP_I), .arvalid_i(CSR_ARVALID_O),
		.arready_o(CSR_ARREADY_I), .araddr_i(CSR_ARADDR_O),
		.rvalid_o(CSR_RVALID_I), .rready_i(CSR_RREADY_O), .rdata_o(CSR_RDATA_I),
		.rresp_o(CSR_RRESP_I));

	// ====
	// Clock, outbound monitor, reporting
	initial forever #12.5 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
		if (OUTBOUND_VALID_O && OUTBOUND_READY_I && STREAM_PORT_CLOCK_EN_I)
			obq.push_back({OUTBOUND_LAST_BEAT_O, OUTBOUND_HEADER_VALID_O,
				OUTBOUND_BYTE_QUALIFIER_O, OUTBOUND_DATA_O[7:0],
				OUTBOUND_HEADER_BUS_O[7:0]});
	task automatic chk(input bit ok, input string what);
		checked++;
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED at %0t ns: %s", $time, what);
		end
	endtask
	task automatic stop_test;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ====
	// Scenarios
	task automatic ob_scn;
		logic [49:0] b;
		int n, k, full;
		full = -1;
		slow = 1;
		// Tail count on non-last beats must be ignored
		for (n = 0; n < 12; n++) begin
			OB_IN_VALID_I = 1;
			OB_IN_I = '{hdr: 256'h5a, data: 256'(n), tail: 6'h3, last: n == 11};
			for (k = 0; k < 40 && !OB_IN_READY_O; k++) begin
				@(negedge CLK_I);
				if (k == 6) full = n;
				if (k == 6) slow = 0;
			end
			@(negedge CLK_I);
		end
		OB_IN_VALID_I = 0;
		chk(full >= 8 && full <= 10, "buffer refusal point");
		for (k = 0; k < 80 && obq.size() < 12; k++) begin
			@(negedge CLK_I);
			slow = k[0];
			STREAM_PORT_CLOCK_EN_I = k[1];
		end
		slow = 0;
		STREAM_PORT_CLOCK_EN_I = 1;
		chk(obq.size() == 12, "outbound beat count");
		for (n = 0; n < 12 && obq.size() > 0; n++) begin
			b = obq.pop_front();
			chk(b[49] === (n == 11), "last flag");
			chk(b[48] === (n == 0), "header valid");
			chk(b[47:16] === (n == 11 ? 32'h7 : '1), "byte lanes");
			chk(b[15:8] === 8'(n), "data order");
			chk(b[7:0] === (n == 0 ? 8'h5a : 8'h00), "header bus");
		end
	endtask
	task automatic ib_beat(input logic hv, input logic [31:0] kp,
		input logic lst, input logic [7:0] d);
		dpf_pkg::dpf_ib_beat_t e;
		int k;
		e = '{hdr: hv ? 256'hc3 : '0, hvalid: hv, data: 256'(d), keep: kp,
			last: lst};
		INBOUND_VALID_I = 1;
		{INBOUND_HEADER_VALID_I, INBOUND_HEADER_BUS_I} = {hv, 256'hc3};
		{INBOUND_DATA_I, INBOUND_BYTE_QUALIFIER_I} = {256'(d), kp};
		INBOUND_LAST_BEAT_I = lst;
		for (k = 0; k < 20 && !INBOUND_READY_O; k++) @(negedge CLK_I);
		@(negedge CLK_I);
		INBOUND_VALID_I = 0;
		INBOUND_HEADER_BUS_I = ~INBOUND_HEADER_BUS_I;
		INBOUND_DATA_I = ~INBOUND_DATA_I;
		repeat (2) @(negedge CLK_I);
		chk(IB_OUT_VALID_O === 1'b1 && INBOUND_READY_O === 1'b0, "rx stall");
		chk(IB_OUT_O === e, "rx beat");
		IB_OUT_READY_I = 1;
		@(negedge CLK_I);
		IB_OUT_READY_I = 0;
	endtask
	task automatic csr(input logic w, input logic [19:0] a,
		input logic [31:0] d, input logic [3:0] s, input int hold,
		input logic [31:0] ed, input logic [1:0] er);
		int k;
		slow = hold > 0;
		CMD_VALID_I = 1;
		CMD_I = '{write: w, addr: a, wdata: d, wstrb: s};
		for (k = 0; k < 20 && !CMD_READY_O; k++) @(negedge CLK_I);
		@(negedge CLK_I);
		CMD_VALID_I = 0;
		CMD_I = ~CMD_I;
		repeat (hold) @(negedge CLK_I);
		if (hold > 0 && w) chk(CSR_AWVALID_O & CSR_WVALID_O & (CSR_AWADDR_O === a)
			& (CSR_WDATA_O === d) & (CSR_WSTRB_O === s), "write held");
		if (hold > 0 && !w) chk(CSR_ARVALID_O & (CSR_ARADDR_O === a), "rd held");
		slow = 0;
		for (k = 0; k < 20 && !RSP_VALID_O; k++) @(negedge CLK_I);
		chk(RSP_VALID_O && RSP_O.resp === er && RSP_O.write === w,
			"csr status");
		if (!w && er == 2'h0) chk(RSP_O.rdata === ed, "csr read data");
		@(negedge CLK_I);
	endtask

	initial begin
		#50000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (5) @(negedge CLK_I);
		SYS_RST_I = 0;
		slow = 0;
		STREAM_PORT_RESET_N_I = 1;
		MEMMAP_PORT_RESET_N_I = 1;
		LITE_PORT_RESET_N_I = 1;
		repeat (2) @(negedge CLK_I);
		chk(MEMMAP_ACTIVE_O === 1'b1 && OB_IN_READY_O === 1'b1, "release");
		ob_scn();
		ib_beat(1, '1, 0, 8'h11);
		ib_beat(0, 32'h0000ffff, 1, 8'h22);
		ib_beat(1, 32'h1, 1, 8'h33);
		LITE_PORT_RESET_N_I = 0;
		@(negedge CLK_I);
		chk(CMD_READY_O === 1'b0 && MEMMAP_ACTIVE_O === 1'b1, "group reset");
		LITE_PORT_RESET_N_I = 1;
		csr(1, 20'h00008, 32'h11223344, 4'hf, 0, 0, 2'h0);
		csr(1, 20'h00008, 32'haabbccdd, 4'h5, 3, 0, 2'h0);
		csr(0, 20'h00008, 0, 0, 3, 32'h11bb33dd, 2'h0);
		csr(1, 20'h10000, 32'h1, 4'hf, 0, 0, 2'h2);
		csr(0, 20'h2f004, 0, 0, 0, 0, 2'h2);
		stop_test();
	end
endmodule
`default_nettype wire
